// ---- logic/lcd_display.sv ----
// Five-segment capacity bar with two-bank multiplexing, blink and blanking.
// Assumes the gauge core writes capacity, charge, temperature band and flags.
// What this block does
// - Show charge relative to full capacity.
// - Each segment is one fifth of capacity.
// - Temperature-correct display, keep stored charge.
// - Request pin at supply blanks the bar.
// - Floating request lights bar on activity.
// - Request pin low enables bar at once.
// - Banks 1,3,5 and 2,4 alternate, never together.
// - About 100 Hz period, 30% per bank.
// - Blink segment one at 4 Hz on warning.
// - Final empty warning blanks the whole bar.
// - Full capacity is the learned full reference.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lcd_display
   import lcd_pkg::*;
#(
   parameter int unsigned SLOT_CYC = SLOT_CYCLES,
   parameter int unsigned BLINK_CYC = BLINK_HALF_CYCLES
)
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out,
   // Display control pin sense
   input wire logic show_request_n_in,
   input wire logic show_request_float_in,
   // LED drive
   output logic [4:0] led_bar_outputs_out,
   output logic led_common_drive_out
);
   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   lcd_bus_type bus;
   assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
   logic [15:0] full_capacity_reference_q;
   logic [15:0] available_charge_count_q;
   logic [3:0] temperature_gauge_register_q;
   lcd_flags_type flags_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   wire logic wr_cap = bus.wr && (bus.addr == FULL_CAP_OFS);
   wire logic wr_avail = bus.wr && (bus.addr == AVAIL_OFS);
   wire logic wr_temp = bus.wr && (bus.addr == TEMP_OFS);
   wire logic wr_flags = bus.wr && (bus.addr == FLAGS_OFS);
   logic [15:0] status_word;
   always_comb
   begin
      rdata_d = 16'h0000;
      if (bus.rd)
      begin
         case (bus.addr)
            FULL_CAP_OFS: rdata_d = full_capacity_reference_q;
            AVAIL_OFS: rdata_d = available_charge_count_q;
            TEMP_OFS: rdata_d = {12'h000, temperature_gauge_register_q};
            FLAGS_OFS: rdata_d = {12'h000, flags_q};
            STATUS_OFS: rdata_d = status_word;
            default: rdata_d = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         full_capacity_reference_q <= FULL_CAP_RST;
         available_charge_count_q <= AVAIL_RST;
         temperature_gauge_register_q <= TEMP_RST;
         flags_q <= '0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         if (wr_cap)
            full_capacity_reference_q <= bus.wdata;
         if (wr_avail)
            available_charge_count_q <= bus.wdata;
         if (wr_temp)
            temperature_gauge_register_q <= bus.wdata[3:0];
         if (wr_flags)
            flags_q <= bus.wdata[3:0];
         rdata_q <= rdata_d;
      end
   end
   // Read data fall back to zero outside the answer cycle, so no stale word lingers on the port.
   assign reg_rdata_out = rdata_q;
   // ---------------------------------------------------------------
   // Temperature-adjusted level
   // ---------------------------------------------------------------
   // The correction works on a copy; the stored charge count is never written here.
   logic [4:0] temp_factor;
   always_comb
   begin
      case (temperature_gauge_register_q)
         4'h0: temp_factor = 5'h08;
         4'h1: temp_factor = 5'h0a;
         4'h2: temp_factor = 5'h0c;
         4'h3: temp_factor = 5'h0d;
         4'h4: temp_factor = 5'h0e;
         4'h5: temp_factor = 5'h0f;
         4'h6, 4'h7, 4'h8: temp_factor = 5'h10;
         default: temp_factor = 5'h0f;
      endcase
   end
   wire logic [20:0] adj_product = 21'(available_charge_count_q) * 21'(temp_factor);
   // The fraction below one count is kept, so the smallest charge still lights segment one.
   // Comparing in sixteenths costs a wider comparator but needs no divider.
   wire logic [23:0] adj_times5 = 24'(adj_product) * 24'h000005;
   logic [4:0] level_mask;
   genvar k;
   generate
      for (k = 0; k < 5; k++)
      begin : g_seg
         // Segment k+1 lights when 5*charge exceeds k times full capacity, both in sixteenths.
         assign level_mask[k] = adj_times5 > (24'(full_capacity_reference_q) * 24'(16 * k));
      end
   endgenerate
   // ---------------------------------------------------------------
   // Enable decision
   // ---------------------------------------------------------------
   wire logic activity = flags_q.dsg || flags_q.chg;
   wire logic req_supply = show_request_n_in && !show_request_float_in;
   wire logic req_low = !show_request_n_in && !show_request_float_in;
   // Final empty is tested first, so a held button cannot light a collapsing battery.
   logic enabled;
   always_comb
   begin
      if (flags_q.final_empty_warning)
         enabled = 1'b0;
      else if (show_request_float_in)
         enabled = activity;
      else if (req_low)
         enabled = 1'b1;
      else
         enabled = 1'b0;
   end
   // ---------------------------------------------------------------
   // Multiplex timing
   // ---------------------------------------------------------------
   logic slot_tick;
   logic blink_tick;
   // Both rates come from free-running dividers; the blink phase is not tied to the slots.
   lcd_tick #(.DIV(SLOT_CYC)) u_slot_tick
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tick_out(slot_tick)
   );
   lcd_tick #(.DIV(BLINK_CYC)) u_blink_tick
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tick_out(blink_tick)
   );
   logic [3:0] slot_q;
   logic blink_on_q;
   wire logic [3:0] slot_d = (slot_q == SLOT_LAST) ? 4'h0 : slot_q + 4'h1;
   lcd_phase_type phase;
   always_comb
   begin
      if (slot_q >= BANK_A_FIRST && slot_q <= BANK_A_LAST)
         phase = LCD_BANK_A;
      else if (slot_q >= BANK_B_FIRST && slot_q <= BANK_B_LAST)
         phase = LCD_BANK_B;
      else
         phase = LCD_OFF;
   end
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         slot_q <= 4'h0;
         blink_on_q <= 1'b1;
      end
      else
      begin
         if (slot_tick)
            slot_q <= slot_d;
         if (blink_tick)
            blink_on_q <= !blink_on_q;
      end
   end
   // ---------------------------------------------------------------
   // Segment drive
   // ---------------------------------------------------------------
   logic [4:0] bank_mask;
   always_comb
   begin
      case (phase)
         LCD_BANK_A: bank_mask = BANK_A_MASK;
         LCD_BANK_B: bank_mask = BANK_B_MASK;
         LCD_OFF: bank_mask = 5'h00;
         default: bank_mask = 5'h00;
      endcase
   end
   // Blinking only masks segment one; higher segments keep their level.
   wire logic [4:0] blink_mask = (flags_q.first_empty_warning && !blink_on_q) ? ~SEG_FIRST_MASK : 5'h1f;
   wire logic [4:0] seg_d = enabled ? (level_mask & bank_mask & blink_mask) : 5'h00;
   wire logic com_d = enabled && (phase != LCD_OFF);
   logic [4:0] seg_q;
   logic com_q;
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         seg_q <= 5'h00;
         com_q <= 1'b0;
      end
      else
      begin
         seg_q <= seg_d;
         com_q <= com_d;
      end
   end
   assign led_bar_outputs_out = seg_q;
   assign led_common_drive_out = com_q;
   assign status_word = {8'h00, blink_on_q, (phase == LCD_BANK_B), enabled, level_mask};
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   a_bank_exclusive: assert property (!(|(seg_q & BANK_A_MASK) && |(seg_q & BANK_B_MASK)))
      else $error("Both segment banks lit together.");
   a_final_blank: assert property (flags_q.final_empty_warning |=> seg_q == 5'h00 && !com_q)
      else $error("Bar lit under final empty warning.");
   a_supply_blank: assert property (req_supply |=> seg_q == 5'h00)
      else $error("Bar lit with request pin at supply.");
   a_low_enable: assert property (req_low && !flags_q.final_empty_warning && phase != LCD_OFF |=> com_q)
      else $error("Low request did not enable the bar.");
   a_float_idle: assert property (show_request_float_in && !activity |=> seg_q == 5'h00)
      else $error("Floating request lit bar without activity.");
   a_common_gate: assert property (seg_q != 5'h00 |-> com_q)
      else $error("Segment lit without common drive.");
   a_common_slots: assert property (com_q |-> $past(slot_q) <= BANK_A_LAST
      || ($past(slot_q) >= BANK_B_FIRST && $past(slot_q) <= BANK_B_LAST))
      else $error("Common drive outside a bank slot.");
   a_slot_range: assert property (slot_q <= SLOT_LAST)
      else $error("Slot counter out of range.");
   a_first_seg: assert property (enabled && phase == LCD_BANK_A && adj_product != 21'h000000
      && !flags_q.first_empty_warning |=> seg_q[0])
      else $error("First segment dark while charge remains.");
   a_blink_dark: assert property (flags_q.first_empty_warning && !blink_on_q |=> !seg_q[0])
      else $error("First segment lit in blink off phase.");
   a_charge_kept: assert property (!$past(wr_avail) |-> $stable(available_charge_count_q))
      else $error("Stored charge changed without a write.");
   a_read_avail: assert property (bus.rd && bus.addr == AVAIL_OFS
      |=> reg_rdata_out == $past(available_charge_count_q))
      else $error("Charge read back differs from stored count.");
   a_temp_write: assert property (wr_temp |=> temperature_gauge_register_q == $past(bus.wdata[3:0]))
      else $error("Temperature band write lost.");
   a_cap_write: assert property (wr_cap |=> full_capacity_reference_q == $past(bus.wdata))
      else $error("Full capacity write lost.");
   a_full_lit: assert property (temperature_gauge_register_q == 4'h6 && full_capacity_reference_q != 16'h0000
      && available_charge_count_q >= full_capacity_reference_q |-> level_mask == 5'h1f)
      else $error("Full charge does not light every segment.");
   a_level_order: assert property (((level_mask >> 1) & ~level_mask) == 5'h00)
      else $error("Level mask is not a bar.");
   a_level_only: assert property ((seg_q & ~$past(level_mask)) == 5'h00)
      else $error("Segment lit above the charge level.");
   // ---------------------------------------------------------------
   // Timing checks
   // ---------------------------------------------------------------
   // The outputs lag the slot by one cycle, so these look at the previous slot state.
   a_bank_b_slots: assert property (com_q && (|(seg_q & BANK_B_MASK)) |-> $past(slot_q) >= BANK_B_FIRST
      && $past(slot_q) <= BANK_B_LAST)
      else $error("Second bank lit outside its slots.");
   a_bank_a_only: assert property (phase == LCD_BANK_A |=> (seg_q & BANK_B_MASK) == 5'h00)
      else $error("Second bank lit in first bank phase.");
   a_bank_b_only: assert property (phase == LCD_BANK_B |=> (seg_q & BANK_A_MASK) == 5'h00)
      else $error("First bank lit in second bank phase.");
   a_dark_slots: assert property (phase == LCD_OFF |=> !com_q && seg_q == 5'h00)
      else $error("Bar driven in a dark slot.");
   a_slot_step: assert property (!$past(slot_tick) |-> $stable(slot_q))
      else $error("Slot moved without a slot tick.");
   a_blink_steady: assert property (!$past(blink_tick) |-> $stable(blink_on_q))
      else $error("Blink phase moved without a blink tick.");
   a_blink_lit: assert property (flags_q.first_empty_warning && blink_on_q && enabled && phase == LCD_BANK_A
      && level_mask[0] |=> seg_q[0])
      else $error("First segment dark in blink on phase.");
   a_first_empty_warning_rest: assert property (flags_q.first_empty_warning && enabled && phase == LCD_BANK_A
      && level_mask[2] |=> seg_q[2])
      else $error("Blink darkened a higher segment.");
   a_supply_com: assert property (req_supply |=> !com_q)
      else $error("Common driven with request pin at supply.");
   a_float_active: assert property (show_request_float_in && activity && !flags_q.final_empty_warning && phase != LCD_OFF |=> com_q)
      else $error("Activity did not enable a floating request.");
   a_com_disabled: assert property (!enabled |=> !com_q)
      else $error("Common driven while the bar is disabled.");
   a_common_low: assert property (req_low && !flags_q.final_empty_warning && phase == LCD_OFF |=> !com_q)
      else $error("Common driven in a dark slot.");
endmodule
`default_nettype wire

// ---- logic/lcd_pkg.sv ----
// Shared constants and types for the capacity bar display.
// Assumes one 200 MHz clock and a plain register port from the gauge core.
package lcd_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned MUX_PERIOD_US = 10000;
   localparam int unsigned MUX_SLOTS = 10;
   localparam int unsigned SLOT_CYCLES = MUX_PERIOD_US * CLK_MHZ / MUX_SLOTS;
   localparam int unsigned BLINK_HALF_US = 125000;
   localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_US * CLK_MHZ;
   localparam logic [3:0] BANK_A_FIRST = 4'h0;
   localparam logic [3:0] BANK_A_LAST = 4'h2;
   localparam logic [3:0] BANK_B_FIRST = 4'h5;
   localparam logic [3:0] BANK_B_LAST = 4'h7;
   localparam logic [3:0] SLOT_LAST = 4'h9;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] FULL_CAP_OFS = 8'h00;
   localparam logic [7:0] AVAIL_OFS = 8'h04;
   localparam logic [7:0] TEMP_OFS = 8'h08;
   localparam logic [7:0] FLAGS_OFS = 8'h0c;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [15:0] FULL_CAP_RST = 16'h0100;
   localparam logic [15:0] AVAIL_RST = 16'h0000;
   localparam logic [3:0] TEMP_RST = 4'h6;
   localparam int unsigned FLAG_FIRST_EMPTY_WARNING = 0;
   localparam int unsigned FLAG_FINAL_EMPTY_WARNING = 1;
   localparam int unsigned FLAG_DSG = 2;
   localparam int unsigned FLAG_CHG = 3;
   localparam logic [4:0] BANK_A_MASK = 5'h15;
   localparam logic [4:0] BANK_B_MASK = 5'h0a;
   localparam logic [4:0] SEG_FIRST_MASK = 5'h01;
   typedef struct packed {
      logic chg;
      logic dsg;
      logic final_empty_warning;
      logic first_empty_warning;
   } lcd_flags_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } lcd_bus_type;
   typedef enum logic [1:0] {
      LCD_OFF,
      LCD_BANK_A,
      LCD_BANK_B
   } lcd_phase_type;
endpackage

// ---- logic/lcd_tick.sv ----
// One-cycle enable pulse every DIV clock cycles.
// Assumes a free-running clock; the count restarts at reset.
`timescale 1ns/1ps
`default_nettype none
module lcd_tick
#(
   parameter int unsigned DIV = 4
)
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Pulse
   output logic tick_out
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   wire logic at_end = (cnt_q == 32'(DIV - 1));
   assign cnt_d = at_end ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
   assign tick_out = at_end;
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_q <= 32'h0000_0000;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// ---- bench/lcd_pin_model.sv ----
// Model of the display request pin: tied high, floating or button pressed.
// Assumes the bench picks the pin mode just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module lcd_pin_model
(
   // Clock
   input wire logic core_clk_in,
   // Pin mode: 0 tied high, 1 floating, 2 pressed
   input wire logic [1:0] mode_in,
   // Pin sense
   output logic show_request_n_out,
   output logic show_request_float_out
);
   logic wobble_q = 1'b0;
   // A floating pin has no level, so it toggles to catch a design that reads it.
   always @(posedge core_clk_in)
      wobble_q <= ~wobble_q;
   assign show_request_float_out = (mode_in == 2'h1);
   assign show_request_n_out = (mode_in == 2'h1) ? wobble_q : (mode_in != 2'h2);
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the capacity bar display.
// Assumes short slot and blink counts set through the parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import lcd_pkg::*;
   localparam int SC = 4;
   // Blink period differs from the mux period, so both blink phases meet the first bank.
   localparam int BC = 30;
   localparam int PER = 10 * SC;
   logic clk = 1'b0;
   logic rst = 1'b1;
   lcd_bus_type bus = '0;
   logic [1:0] mode = 2'h0;
   logic [15:0] rdata;
   logic [4:0] leds;
   logic com;
   logic req_n;
   logic flt;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int ca;
   int cb;
   int cz;
   int on1;
   int off1;
   // ----------------------------------------
   // Clock, reset and instances
   // ----------------------------------------
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   lcd_pin_model lcd_pin_model_i (.core_clk_in(clk), .mode_in(mode),
      .show_request_n_out(req_n), .show_request_float_out(flt));
   lcd_display #(.SLOT_CYC(SC), .BLINK_CYC(BC)) lcd_display_i (.core_clk_in(clk),
      .rst_in(rst), .reg_addr_in(bus.addr), .reg_wdata_in(bus.wdata), .reg_wr_in(bus.wr),
      .reg_rd_in(bus.rd), .reg_rdata_out(rdata), .show_request_n_in(req_n),
      .show_request_float_in(flt), .led_bar_outputs_out(leds), .led_common_drive_out(com));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(posedge clk);
      mode <= m;
   endtask
   // The read word stands only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      @(negedge clk);
      check("read", rdata & m, exp);
   endtask
   // One full mux period seen from any phase shows every slot once.
   task automatic observe(input logic [4:0] lvl, input int n);
      ca = 0;
      cb = 0;
      cz = 0;
      on1 = 0;
      off1 = 0;
      repeat (2) @(posedge clk);
      repeat (n)
      begin
         @(negedge clk);
         if (com && leds === (lvl & BANK_A_MASK)) ca++;
         if (com && leds === (lvl & BANK_B_MASK)) cb++;
         if (!com && leds === 5'h00) cz++;
         if (com && leds[2] && leds[0]) on1++;
         if (com && leds[2] && !leds[0]) off1++;
      end
   endtask
   task automatic expect_on(input logic [4:0] lvl);
      observe(lvl, PER);
      check("bank a", ca, 3 * SC);
      check("bank b", cb, 3 * SC);
      check("dark", cz, 4 * SC);
   endtask
   task automatic expect_off();
      observe(5'h1f, PER);
      check("blank", cz, PER);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(FULL_CAP_OFS, 16'hffff, FULL_CAP_RST);
      rd(TEMP_OFS, 16'hffff, 16'h0006);
      rd(AVAIL_OFS, 16'hffff, 16'h0000);
      rd(8'h20, 16'hffff, 16'h0000);
   endtask
   task automatic t_level();
      wr(FULL_CAP_OFS, 16'h0064);
      wr(AVAIL_OFS, 16'h0032);
      rd(STATUS_OFS, 16'h001f, 16'h0007);
      wr(TEMP_OFS, 16'h0000);
      rd(STATUS_OFS, 16'h001f, 16'h0003);
      rd(AVAIL_OFS, 16'hffff, 16'h0032);
      wr(AVAIL_OFS, 16'h0000);
      rd(STATUS_OFS, 16'h001f, 16'h0000);
      wr(AVAIL_OFS, 16'h0001);
      rd(STATUS_OFS, 16'h001f, 16'h0001);
      wr(TEMP_OFS, 16'h0006);
      wr(AVAIL_OFS, 16'h0064);
      rd(STATUS_OFS, 16'h001f, 16'h001f);
   endtask
   task automatic t_modes();
      set_mode(2'h0);
      expect_off();
      set_mode(2'h2);
      expect_on(5'h1f);
      set_mode(2'h1);
      expect_off();
      wr(FLAGS_OFS, 16'h0004);
      expect_on(5'h1f);
      wr(FLAGS_OFS, 16'h0008);
      expect_on(5'h1f);
   endtask
   task automatic t_warn();
      set_mode(2'h2);
      wr(FLAGS_OFS, 16'h0001);
      observe(5'h1f, 4 * BC);
      check("blink on", on1 > 0, 1);
      check("blink off", off1 > 0, 1);
      wr(FLAGS_OFS, 16'h0003);
      expect_off();
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_level();
      t_modes();
      t_warn();
      tally_and_finish();
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end
endmodule
`default_nettype wire
